// ==== inc/wdt_regs.svh ====
// Purpose: Register offsets, field positions, reset values and codes of the watchdog and reset control
// Assumes: Word-aligned Wishbone registers, 8-bit data in low byte
// Notes:   Definitions only
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_WATCHDOG_CONTROL   4'h0
`define OFS_RESET_SOURCE_FLAGS 4'h4
`define OFS_LOW_VOLTAGE_CTRL   4'h8
`define OFS_CORE_STATUS        4'hC

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define WATCHDOG_CONTROL_POR   8'h57
`define LOW_VOLTAGE_CTRL_POR   8'h5A
`define WD_CODE_DISABLE        5'h15
`define WD_CODE_ENABLE         5'h0A
`define LV_CODE_ENABLE         8'h5A
`define LV_CODE_DISABLE        8'hA5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WD_CODE_LSB            3
`define FLAG_WD_CODE           0
`define FLAG_LV_CODE           1
`define FLAG_LV_EVENT          2
`define STAT_TIMEOUT           0
`define STAT_POWER_DOWN        1

// ----------------------------------------
// Timing: slow clock 32 kHz from 40 MHz
// ----------------------------------------
`define CLK_HZ                 40000000
`define SLOW_CLOCK_HZ          32000
`define SLOW_DIV_CYCLES        (`CLK_HZ / `SLOW_CLOCK_HZ)

`endif

// ==== inc/wdt_pkg.sv ====
// Purpose: Types of the watchdog and reset control
// Assumes: Nothing
// Notes:   Offsets and codes live in wdt_regs.svh
package wdt_pkg;

	typedef enum logic [2:0] {
		RUN_MODE   = 3'b001,
		HALT_MODE  = 3'b010,
		RESET_MODE = 3'b100
	} run_state_t;

endpackage

// ==== core/slow_tick.sv ====
// Purpose: Slow-clock enable pulse derived from the system clock
// Assumes: One clock, synchronous reset
// Notes:   One pulse every DIV cycles
`timescale 1ns/100ps
module slow_tick #(
	parameter int DIV = 1250
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	output logic      tick_o
);
	initial begin
		if (DIV < 2 || DIV > 65536) begin
			$error("slow_tick: DIV must be between 2 and 65536");
		end
	end

	logic [15:0] cnt_q;

	always_ff @(posedge clk_i) begin
		if (rst_i || cnt_q == 16'(DIV - 1)) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk_i) begin
		tick_o <= !rst_i && cnt_q == 16'(DIV - 1);
	end
endmodule

// ==== core/watchdog_and_reset_control.sv ====
// Purpose: Watchdog timer, reset-source flags, low-voltage reset and halt wake-up control
// Assumes: Wishbone classic slave, 40 MHz clk_i, core signals synchronous to clk_i
// Notes:   Summary of operation below
//
// Summary of operation
// - Port falling-edge wake resumes at instruction after halt.
// - Disabled interrupt or full stack wake resumes after halt, service deferred.
// - Enabled interrupt with stack room wakes into normal interrupt response.
// - Interrupt already pending at halt entry cannot wake the device.
// - Watchdog counts slow clock, tap selectable from 2^8 to 2^15.
// - Period select n gives timeout of 2^(8+n) slow clocks from a cleared count.
// - Code 10101 disables, 01010 enables, anything else resets after delay.
// - Invalid watchdog code reset sets flag bit 0.
// - Watchdog code reset flag stays set until software clears it.
// - Watchdog code field powers up enabled.
// - Overflow while running gives full reset and sets timeout flag.
// - Overflow in halt sets timeout flag and resets only PC and SP.
// - Invalid code, clear instruction or halt clears watchdog count.
// - Low-voltage code 01011010 enables 2.1V reset, 10100101 disables.
// - Low-voltage reset only after undervoltage lasts the qualification time.
// - Genuine low-voltage reset keeps low-voltage control contents.
// - Invalid low-voltage code resets after delay, sets flag, reloads register.
// - Low-voltage reset inactive in halt modes.
// - Low-voltage flags stay set until software clears them.
// - Power-on clears PC and sets port data and direction high.
// - Upper five bits of reset flag register read zero.
// - Power-down flag set by halt, cleared by power-up or clear instruction.
// - Halt clears timeout flag and count, counting resumes only if enabled.
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "wdt_regs.svh"
module watchdog_and_reset_control #(
	parameter int SOFTWARE_RESET_DELAY     = 4,
	parameter int UNDERVOLTAGE_QUALIFY_TIME = 4,
	parameter int SLOW_DIV                 = `SLOW_DIV_CYCLES,
	parameter int PORT_WIDTH               = 6
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [3:0]            adr_i,
	input  wire logic [3:0]            sel_i,
	input  wire logic [31:0]           dat_i,
	output logic      [31:0]           dat_o,
	output logic                       ack_o,
	input  wire logic                  halt_instr_i,
	input  wire logic                  clear_watchdog_instruction_i,
	input  wire logic [PORT_WIDTH-1:0] port_pins_i,
	input  wire logic [PORT_WIDTH-1:0] port_wake_enable_i,
	input  wire logic                  irq_request_i,
	input  wire logic                  irq_enabled_i,
	input  wire logic                  stack_full_i,
	input  wire logic                  undervoltage_i,
	output logic                       system_reset_o,
	output logic                       pc_sp_reset_o,
	output logic                       halted_o,
	output logic                       wake_resume_o,
	output logic                       wake_service_irq_o,
	output logic                       port_init_high_o
);
	initial begin
		if (SOFTWARE_RESET_DELAY < 1 || SOFTWARE_RESET_DELAY > 255 ||
		    UNDERVOLTAGE_QUALIFY_TIME < 1 || UNDERVOLTAGE_QUALIFY_TIME > 255 || PORT_WIDTH < 1) begin
			$error("watchdog_and_reset_control: parameter out of range");
		end
	end

	// ----------------------------------------
	// Slow clock enable and pin synchronisers
	// ----------------------------------------
	logic                  slow_tick;
	logic [PORT_WIDTH-1:0] pin_meta_q;
	logic [PORT_WIDTH-1:0] pin_sync_q;
	logic [PORT_WIDTH-1:0] pin_prev_q;
	logic                  uv_meta_q;
	logic                  uv_sync_q;

	slow_tick #(
		.DIV(SLOW_DIV)
	) u_slow_tick (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.tick_o(slow_tick)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta_q <= '1;
			pin_sync_q <= '1;
			pin_prev_q <= '1;
			uv_meta_q  <= 1'b0;
			uv_sync_q  <= 1'b0;
		end else begin
			pin_meta_q <= port_pins_i;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
			uv_meta_q  <= undervoltage_i;
			uv_sync_q  <= uv_meta_q;
		end
	end

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	logic [7:0]              watchdog_control_q;
	logic [7:0]              low_voltage_code_q;
	logic                    watchdog_code_reset_flag_q;
	logic                    low_voltage_code_reset_flag_q;
	logic                    low_voltage_event_flag_q;
	logic                    timeout_flag_q;
	logic                    power_down_flag_q;
	logic [15:0]             wd_count_q;
	logic [7:0]              wd_delay_q;
	logic [7:0]              lv_delay_q;
	logic [7:0]              uv_count_q;
	logic                    irq_pending_at_halt_q;
	wdt_pkg::run_state_t     state_q;

	logic [4:0]  watchdog_function_code;
	logic [2:0]  watchdog_period_select;
	logic        wd_code_bad;
	logic        lv_code_bad;
	logic        wd_enabled;
	logic        lv_enabled;
	logic        wd_overflow;
	logic        uv_qualified;
	logic        halted;
	logic        bus_wr;
	logic        port_wake;
	logic        irq_wake;
	logic        full_reset;

	assign watchdog_function_code = watchdog_control_q[7:`WD_CODE_LSB];
	assign watchdog_period_select = watchdog_control_q[2:0];
	assign wd_code_bad  = watchdog_function_code != `WD_CODE_ENABLE && watchdog_function_code != `WD_CODE_DISABLE;
	assign lv_code_bad  = low_voltage_code_q != `LV_CODE_ENABLE && low_voltage_code_q != `LV_CODE_DISABLE;
	assign wd_enabled   = watchdog_function_code == `WD_CODE_ENABLE;
	assign halted       = state_q == wdt_pkg::HALT_MODE;
	assign lv_enabled   = low_voltage_code_q == `LV_CODE_ENABLE && !halted;
	// Tap at bit 8+n; clear and halt zero the whole count, so the next period is a full 2^(8+n) slow ticks
	assign wd_overflow  = slow_tick && wd_enabled &&
	                      wd_count_q == 16'((32'h1 << (8 + watchdog_period_select)) - 1);
	assign uv_qualified = lv_enabled && uv_sync_q && slow_tick &&
	                      uv_count_q == 8'(UNDERVOLTAGE_QUALIFY_TIME);
	assign bus_wr       = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
	assign port_wake    = |(pin_prev_q & ~pin_sync_q & port_wake_enable_i);
	assign irq_wake     = irq_request_i && !irq_pending_at_halt_q;
	assign full_reset   = (wd_overflow && !halted) ||
	                      (wd_code_bad && slow_tick && wd_delay_q == 8'(SOFTWARE_RESET_DELAY)) ||
	                      (lv_code_bad && slow_tick && lv_delay_q == 8'(SOFTWARE_RESET_DELAY)) ||
	                      uv_qualified;

	// ----------------------------------------
	// Watchdog control register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			watchdog_control_q <= `WATCHDOG_CONTROL_POR;
		end else if (bus_wr && adr_i == `OFS_WATCHDOG_CONTROL) begin
			watchdog_control_q <= dat_i[7:0];
		end
	end

	// ----------------------------------------
	// Low-voltage control register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_voltage_code_q <= `LOW_VOLTAGE_CTRL_POR;
		end else if (lv_code_bad && slow_tick && lv_delay_q == 8'(SOFTWARE_RESET_DELAY)) begin
			low_voltage_code_q <= `LOW_VOLTAGE_CTRL_POR;
		end else if (bus_wr && adr_i == `OFS_LOW_VOLTAGE_CTRL) begin
			low_voltage_code_q <= dat_i[7:0];
		end
	end

	// ----------------------------------------
	// Software reset delays and undervoltage qualifier
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || !wd_code_bad) begin
			wd_delay_q <= 8'h00;
		end else if (slow_tick && wd_delay_q != 8'(SOFTWARE_RESET_DELAY)) begin
			wd_delay_q <= wd_delay_q + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !lv_code_bad) begin
			lv_delay_q <= 8'h00;
		end else if (slow_tick && lv_delay_q != 8'(SOFTWARE_RESET_DELAY)) begin
			lv_delay_q <= lv_delay_q + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !uv_sync_q || !lv_enabled) begin
			uv_count_q <= 8'h00;
		end else if (slow_tick && uv_count_q != 8'(UNDERVOLTAGE_QUALIFY_TIME)) begin
			uv_count_q <= uv_count_q + 8'h01;
		end
	end

	// ----------------------------------------
	// Watchdog counter
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i || wd_code_bad || clear_watchdog_instruction_i || halt_instr_i || wd_overflow) begin
			wd_count_q <= 16'h0000;
		end else if (slow_tick && wd_enabled) begin
			wd_count_q <= wd_count_q + 16'h0001;
		end
	end

	// ----------------------------------------
	// Reset-source flags (set wins over clear)
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			watchdog_code_reset_flag_q    <= 1'b0;
			low_voltage_code_reset_flag_q <= 1'b0;
			low_voltage_event_flag_q      <= 1'b0;
		end else begin
			if (bus_wr && adr_i == `OFS_RESET_SOURCE_FLAGS) begin
				watchdog_code_reset_flag_q    <= dat_i[`FLAG_WD_CODE] & watchdog_code_reset_flag_q;
				low_voltage_code_reset_flag_q <= dat_i[`FLAG_LV_CODE] & low_voltage_code_reset_flag_q;
				low_voltage_event_flag_q      <= dat_i[`FLAG_LV_EVENT] & low_voltage_event_flag_q;
			end
			if (wd_code_bad && slow_tick && wd_delay_q == 8'(SOFTWARE_RESET_DELAY)) begin
				watchdog_code_reset_flag_q <= 1'b1;
			end
			if (lv_code_bad && slow_tick && lv_delay_q == 8'(SOFTWARE_RESET_DELAY)) begin
				low_voltage_code_reset_flag_q <= 1'b1;
			end
			if (uv_qualified) begin
				low_voltage_event_flag_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timeout_flag_q    <= 1'b0;
			power_down_flag_q <= 1'b0;
		end else begin
			if (wd_overflow) begin
				timeout_flag_q <= 1'b1;
			end else if (halt_instr_i && state_q == wdt_pkg::RUN_MODE) begin
				timeout_flag_q <= 1'b0;
			end
			if (halt_instr_i && state_q == wdt_pkg::RUN_MODE) begin
				power_down_flag_q <= 1'b1;
			end else if (clear_watchdog_instruction_i) begin
				power_down_flag_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Run, halt and reset sequencing
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q               <= wdt_pkg::RESET_MODE;
			irq_pending_at_halt_q <= 1'b0;
			system_reset_o        <= 1'b1;
			pc_sp_reset_o         <= 1'b1;
			port_init_high_o      <= 1'b1;
			halted_o              <= 1'b0;
			wake_resume_o         <= 1'b0;
			wake_service_irq_o    <= 1'b0;
		end else begin
			system_reset_o     <= 1'b0;
			pc_sp_reset_o      <= 1'b0;
			port_init_high_o   <= 1'b0;
			wake_resume_o      <= 1'b0;
			wake_service_irq_o <= 1'b0;
			case (state_q)
				wdt_pkg::RESET_MODE: begin
					state_q <= wdt_pkg::RUN_MODE;
				end
				wdt_pkg::RUN_MODE: begin
					if (full_reset) begin
						system_reset_o   <= 1'b1;
						pc_sp_reset_o    <= 1'b1;
						port_init_high_o <= 1'b1;
						state_q          <= wdt_pkg::RESET_MODE;
					end else if (halt_instr_i) begin
						irq_pending_at_halt_q <= irq_request_i;
						halted_o              <= 1'b1;
						state_q               <= wdt_pkg::HALT_MODE;
					end
				end
				wdt_pkg::HALT_MODE: begin
					if (wd_overflow) begin
						pc_sp_reset_o <= 1'b1;
						halted_o      <= 1'b0;
						state_q       <= wdt_pkg::RUN_MODE;
					end else if (full_reset) begin
						system_reset_o   <= 1'b1;
						pc_sp_reset_o    <= 1'b1;
						port_init_high_o <= 1'b1;
						halted_o         <= 1'b0;
						state_q          <= wdt_pkg::RESET_MODE;
					end else if (port_wake) begin
						wake_resume_o <= 1'b1;
						halted_o      <= 1'b0;
						state_q       <= wdt_pkg::RUN_MODE;
					end else if (irq_wake) begin
						if (irq_enabled_i && !stack_full_i) begin
							wake_service_irq_o <= 1'b1;
						end else begin
							wake_resume_o <= 1'b1;
						end
						halted_o <= 1'b0;
						state_q  <= wdt_pkg::RUN_MODE;
					end
				end
				default: begin
					state_q <= wdt_pkg::RESET_MODE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Wishbone read data and acknowledge
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= cyc_i && stb_i && !ack_o;
			if (adr_i == `OFS_WATCHDOG_CONTROL) begin
				dat_o <= {24'h000000, watchdog_control_q};
			end else if (adr_i == `OFS_RESET_SOURCE_FLAGS) begin
				dat_o <= {29'h00000000, low_voltage_event_flag_q, low_voltage_code_reset_flag_q,
				          watchdog_code_reset_flag_q};
			end else if (adr_i == `OFS_LOW_VOLTAGE_CTRL) begin
				dat_o <= {24'h000000, low_voltage_code_q};
			end else if (adr_i == `OFS_CORE_STATUS) begin
				dat_o <= {30'h00000000, power_down_flag_q, timeout_flag_q};
			end else begin
				dat_o <= 32'h00000000;
			end
		end
	end
endmodule

// ==== test/watchdog_and_reset_control_assertions.sv ====
// Purpose: Port-level checks of the watchdog and reset control
// Assumes: Bound to the top module, one clock
// Notes:   CODE_WAIT bound scales with SLOW_DIV; the pending and dip windows are fixed at 8 cycles
`timescale 1ns/100ps
`include "wdt_regs.svh"
module watchdog_and_reset_control_assertions #(
	parameter int SOFTWARE_RESET_DELAY      = 4,
	parameter int UNDERVOLTAGE_QUALIFY_TIME = 4,
	parameter int SLOW_DIV                  = 2,
	parameter int PORT_WIDTH                = 6
) (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  cyc_i,
	input wire logic                  stb_i,
	input wire logic                  we_i,
	input wire logic [3:0]            adr_i,
	input wire logic [3:0]            sel_i,
	input wire logic [31:0]           dat_i,
	input wire logic [31:0]           dat_o,
	input wire logic                  ack_o,
	input wire logic                  halt_instr_i,
	input wire logic                  clear_watchdog_instruction_i,
	input wire logic [PORT_WIDTH-1:0] port_pins_i,
	input wire logic [PORT_WIDTH-1:0] port_wake_enable_i,
	input wire logic                  irq_request_i,
	input wire logic                  irq_enabled_i,
	input wire logic                  stack_full_i,
	input wire logic                  undervoltage_i,
	input wire logic                  system_reset_o,
	input wire logic                  pc_sp_reset_o,
	input wire logic                  halted_o,
	input wire logic                  wake_resume_o,
	input wire logic                  wake_service_irq_o,
	input wire logic                  port_init_high_o
);
	localparam int CODE_WAIT = (SOFTWARE_RESET_DELAY + 2) * SLOW_DIV + 6;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_RST_RELEASE: assert property ($fell(rst_i) |-> system_reset_o && port_init_high_o ##1 !system_reset_o)
		else $error("reset release sequence wrong");
	AST_FULL_RESET: assert property (system_reset_o |-> port_init_high_o && pc_sp_reset_o)
		else $error("full reset without port init");
	AST_BUS_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("ack not one cycle after request");
	AST_WAKE_EXIT: assert property (wake_resume_o || wake_service_irq_o |-> $past(halted_o) && !halted_o)
		else $error("wake outside halt");
	AST_SERVICE: assert property (wake_service_irq_o |-> $past(irq_enabled_i) && !$past(stack_full_i))
		else $error("irq serviced while disabled or stack full");
	AST_PENDING: assert property (halt_instr_i && irq_request_i && !halted_o && !system_reset_o
		|=> (!wake_service_irq_o && !wake_resume_o) [*8])
		else $error("pending irq woke device");
	AST_HALT: assert property (halt_instr_i && !halted_o && !system_reset_o |=> halted_o)
		else $error("halt not entered");
	AST_PCSP: assert property (pc_sp_reset_o && !system_reset_o |-> $past(halted_o))
		else $error("partial reset outside halt");
	AST_BAD_CODE: assert property (cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i == `OFS_WATCHDOG_CONTROL
		&& !(dat_i[7:3] inside {`WD_CODE_DISABLE, `WD_CODE_ENABLE}) |-> ##[1:CODE_WAIT] system_reset_o)
		else $error("bad watchdog code gave no reset");
	AST_DIP: assert property ($rose(undervoltage_i) ##2 $fell(undervoltage_i) |=> !system_reset_o [*8])
		else $error("short dip caused reset");
endmodule

// ==== test/core_model.sv ====
// Purpose: Processor core stand-in issuing halt and clear-watchdog instructions
// Assumes: Tasks are called at a rising edge of clk_i
// Notes:   Each instruction is a one-cycle pulse
`timescale 1ns/100ps
module core_model (
	input  wire logic clk_i,
	output logic      halt_instr_o = 1'h0,
	output logic      clear_watchdog_instruction_o = 1'h0
);
	task do_halt;
		halt_instr_o <= 1'h1;
		@(posedge clk_i);
		halt_instr_o <= 1'h0;
	endtask
	task do_clear;
		clear_watchdog_instruction_o <= 1'h1;
		@(posedge clk_i);
		clear_watchdog_instruction_o <= 1'h0;
	endtask
endmodule

// ==== test/watchdog_and_reset_control_test.sv ====
// Purpose: Self-checking bench of the watchdog and reset control
// Assumes: Fast slow-clock divider for short runs
// Notes:   Core stand-in issues halt and clear
`timescale 1ns/100ps
module watchdog_and_reset_control_test;
	localparam int DIV = 2;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic [3:0] adr_i, sel_i;
	logic [31:0] dat_i, dat_o, rd;
	logic halt_instr_i, clear_watchdog_instruction_i;
	logic [5:0] port_pins_i, port_wake_enable_i;
	logic irq_request_i, irq_enabled_i, stack_full_i, undervoltage_i;
	logic system_reset_o, pc_sp_reset_o, halted_o, wake_resume_o, wake_service_irq_o, port_init_high_o;
	int bad_count, checks_done, n;

	watchdog_and_reset_control #(.SLOW_DIV(DIV)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .halt_instr_i(halt_instr_i),
		.clear_watchdog_instruction_i(clear_watchdog_instruction_i), .port_pins_i(port_pins_i),
		.port_wake_enable_i(port_wake_enable_i), .irq_request_i(irq_request_i), .irq_enabled_i(irq_enabled_i),
		.stack_full_i(stack_full_i), .undervoltage_i(undervoltage_i), .system_reset_o(system_reset_o),
		.pc_sp_reset_o(pc_sp_reset_o), .halted_o(halted_o), .wake_resume_o(wake_resume_o),
		.wake_service_irq_o(wake_service_irq_o), .port_init_high_o(port_init_high_o));
	core_model core (.clk_i(clk_i), .halt_instr_o(halt_instr_i),
		.clear_watchdog_instruction_o(clear_watchdog_instruction_i));

	initial begin
		clk_i = 1'h0;
		forever #12.5 clk_i = ~clk_i;
	end
	task finish_test;
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			bad_count++;
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'h1);
		rd = dat_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'h1, a, d);
	endtask
	task rd_chk(input string nm, input logic [3:0] a, input logic [31:0] exp);
		bus(1'h0, a, 8'h00);
		check(nm, exp, rd);
	endtask
	function logic outv(input int k);
		case (k)
			0: return system_reset_o;
			1: return pc_sp_reset_o;
			2: return wake_resume_o;
			3: return wake_service_irq_o;
			default: return halted_o;
		endcase
	endfunction
	task wait_hi(input int k, input int lim);
		n = 0;
		while (outv(k) !== 1'h1 && n < lim) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task pin_wake;
		port_pins_i <= 6'h3E;
		wait_hi(2, 10);
		port_pins_i <= 6'h3F;
		@(posedge clk_i);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		rd_chk("wd_ctrl", 4'h0, 32'h57);
		rd_chk("lv_ctrl", 4'h8, 32'h5A);
		rd_chk("flags", 4'h4, 32'h0);
		wr(4'h2, 8'hFF);
		rd_chk("unmapped", 4'h2, 32'h0);
		wr(4'h0, 8'hA8);
		rd_chk("wd_ctrl_rw", 4'h0, 32'hA8);
	endtask
	task t_watchdog;
		int lo;
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, 8'h50 + 8'(i));
			core.do_clear();
			wait_hi(0, 5000);
			lo = ((2 ** (8 + i)) - (2 ** i)) * DIV - 6;
			check("wd_period", 32'h1, 32'(n >= lo && n <= (2 ** (8 + i)) * DIV + 6));
			repeat (4) @(posedge clk_i);
		end
		rd_chk("status_to", 4'hC, 32'h1);
		for (int i = 0; i < 4; i++) begin
			core.do_clear();
			wait_hi(0, 1400);
			check("wd_cleared", 32'h578, n);
		end
		wr(4'h0, 8'hA8);
	endtask
	task t_port_wake;
		port_wake_enable_i <= 6'h01;
		core.do_halt();
		@(posedge clk_i);
		check("halted", 32'h1, halted_o);
		rd_chk("status_halt", 4'hC, 32'h2);
		port_pins_i <= 6'h3D;
		wait_hi(2, 10);
		check("masked_pin", 32'hA, n);
		port_pins_i <= 6'h3C;
		wait_hi(2, 10);
		check("pin_wake", 32'h1, wake_resume_o);
		port_pins_i <= 6'h3F;
		core.do_clear();
		rd_chk("status_clr", 4'hC, 32'h0);
	endtask
	task t_irq;
		logic [2:0] tbl [3] = '{3'h0, 3'h6, 3'h5};
		for (int i = 0; i < 3; i++) begin
			irq_enabled_i <= tbl[i][2];
			stack_full_i <= tbl[i][1];
			core.do_halt();
			irq_request_i <= 1'h1;
			n = 0;
			while (wake_resume_o !== 1'h1 && wake_service_irq_o !== 1'h1 && n < 10) begin
				@(posedge clk_i);
				n++;
			end
			check("irq_service", 32'(tbl[i][0]), wake_service_irq_o);
			check("irq_resume", 32'(!tbl[i][0]), wake_resume_o);
			irq_request_i <= 1'h0;
			@(posedge clk_i);
		end
		irq_request_i <= 1'h1;
		core.do_halt();
		wait_hi(3, 12);
		check("irq_pending", 32'h1, halted_o);
		irq_request_i <= 1'h0;
		pin_wake();
	endtask
	task t_halt_ovf;
		wr(4'h0, 8'h50);
		core.do_halt();
		wait_hi(1, 1200);
		check("ovf_sys", 32'h0, system_reset_o);
		check("ovf_pcsp", 32'h1, pc_sp_reset_o);
		wr(4'h0, 8'hA8);
		rd_chk("status_ovf", 4'hC, 32'h3);
		pin_wake();
		core.do_clear();
	endtask
	task t_bad_codes;
		wr(4'h0, 8'h00);
		wait_hi(0, 40);
		check("wd_bad", 32'h1, system_reset_o);
		repeat (2) @(posedge clk_i);
		wr(4'h0, 8'hA8);
		rd_chk("flag_wd", 4'h4, 32'h1);
		wr(4'h4, 8'hFF);
		rd_chk("flag_keep", 4'h4, 32'h1);
		wr(4'h4, 8'h00);
		rd_chk("flag_clr", 4'h4, 32'h0);
		wr(4'h8, 8'h33);
		wait_hi(0, 40);
		check("lv_bad", 32'h1, system_reset_o);
		repeat (4) @(posedge clk_i);
		rd_chk("lv_reload", 4'h8, 32'h5A);
		rd_chk("flag_lv", 4'h4, 32'h2);
		wr(4'h4, 8'h00);
	endtask
	task t_volts;
		undervoltage_i <= 1'h1;
		wait_hi(0, 60);
		undervoltage_i <= 1'h0;
		check("lv_reset", 32'h1, system_reset_o);
		repeat (4) @(posedge clk_i);
		rd_chk("lv_kept", 4'h8, 32'h5A);
		rd_chk("flag_event", 4'h4, 32'h4);
		wr(4'h4, 8'h00);
		undervoltage_i <= 1'h1;
		repeat (2) @(posedge clk_i);
		undervoltage_i <= 1'h0;
		wait_hi(0, 30);
		check("dip", 32'h1E, n);
		wr(4'h8, 8'hA5);
		undervoltage_i <= 1'h1;
		wait_hi(0, 60);
		undervoltage_i <= 1'h0;
		check("lv_off", 32'h3C, n);
		wr(4'h8, 8'h5A);
		core.do_halt();
		undervoltage_i <= 1'h1;
		wait_hi(0, 60);
		undervoltage_i <= 1'h0;
		check("lv_halt", 32'h3C, n);
		pin_wake();
	endtask

	initial begin
		{cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
		sel_i = 4'h1;
		rst_i = 1'h1;
		port_pins_i = 6'h3F;
		port_wake_enable_i = 6'h00;
		{irq_request_i, irq_enabled_i, stack_full_i, undervoltage_i} = 4'h0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		t_reset();
		t_watchdog();
		t_port_wake();
		t_irq();
		t_halt_ovf();
		t_bad_codes();
		t_volts();
		finish_test();
	end
	initial begin
		repeat (30000) @(posedge clk_i);
		bad_count++;
		finish_test();
	end
endmodule
bind watchdog_and_reset_control watchdog_and_reset_control_assertions #(
	.SOFTWARE_RESET_DELAY(SOFTWARE_RESET_DELAY), .UNDERVOLTAGE_QUALIFY_TIME(UNDERVOLTAGE_QUALIFY_TIME),
	.SLOW_DIV(SLOW_DIV), .PORT_WIDTH(PORT_WIDTH)) chk (
	.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .halt_instr_i(halt_instr_i),
	.clear_watchdog_instruction_i(clear_watchdog_instruction_i), .port_pins_i(port_pins_i),
	.port_wake_enable_i(port_wake_enable_i), .irq_request_i(irq_request_i), .irq_enabled_i(irq_enabled_i),
	.stack_full_i(stack_full_i), .undervoltage_i(undervoltage_i), .system_reset_o(system_reset_o),
	.pc_sp_reset_o(pc_sp_reset_o), .halted_o(halted_o), .wake_resume_o(wake_resume_o),
	.wake_service_irq_o(wake_service_irq_o), .port_init_high_o(port_init_high_o));
